//--- pkg/cphp_pkg.sv
/*
  shared constants, word offsets and key reader states for the
  content protection host ports block.
  assumes one clock and a synchronous active high reset around it.
*/
package cphp_pkg;
  // =====================================================
  // widths
  localparam int unsigned CPHP_ADDR_W = 8;
  localparam int unsigned CPHP_DATA_W = 32;
  localparam int unsigned CPHP_KADDR_W = 10;
  localparam int unsigned CPHP_KQ_W = 88;
  localparam int unsigned CPHP_V2KEY_W = 32;
  localparam int unsigned CPHP_V1KEY_W = 56;
  localparam int unsigned CPHP_MSG_DEPTH = 16;
  // =====================================================
  // word offsets on the register port
  localparam logic [7:0] CPHP_OFS_CTRL = 8'h00;
  localparam logic [7:0] CPHP_OFS_STATUS = 8'h01;
  localparam logic [7:0] CPHP_OFS_V2KEY = 8'h02;
  localparam logic [7:0] CPHP_OFS_V1KEY_LO = 8'h03;
  localparam logic [7:0] CPHP_OFS_V1KEY_HI = 8'h04;
  localparam logic [7:0] CPHP_OFS_MSG_BASE = 8'h10;
  localparam int unsigned CPHP_BYTE_SHIFT = 2;
  // =====================================================
  // field positions
  localparam int unsigned CPHP_CTRL_START_BIT = 0;
  localparam int unsigned CPHP_CTRL_V1_BIT = 1;
  localparam int unsigned CPHP_CTRL_IDX_LSB = 8;
  localparam int unsigned CPHP_STS_BUSY_BIT = 0;
  localparam int unsigned CPHP_STS_DONE_BIT = 1;
  localparam int unsigned CPHP_STS_V2_BIT = 2;
  localparam int unsigned CPHP_STS_V1_BIT = 3;
  localparam int unsigned CPHP_STS_KMGMT_BIT = 4;
  localparam int unsigned CPHP_V1_ADDR_LSB = 4;
  localparam int unsigned CPHP_V1_Q_LSB = 32;
  // =====================================================
  // reset values
  localparam logic [31:0] CPHP_WORD_RST = 32'h0000_0000;
  localparam logic [9:0] CPHP_KADDR_RST = 10'h000;
  localparam logic [55:0] CPHP_V1KEY_RST = 56'h00_0000_0000_0000;
  localparam logic [5:0] CPHP_IDX_RST = 6'h00;
  // =====================================================
  // key reader states, gray along idle-wait-done
  typedef enum logic [1:0] {
    CPHP_K_IDLE = 2'b00,
    CPHP_K_WAIT = 2'b01,
    CPHP_K_DONE = 2'b11
  } cphp_kstate_t;
endpackage

//--- src/cphp_key_reader.sv
/*
  key store read sequencer: drives the key address, waits on the
  store's wait line, samples the returned key one cycle later.
  assumes the store holds wait high until the key is ready.
*/
`timescale 1ns/1ps
`default_nettype none
module cphp_key_reader
  import cphp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic v1_i,
  input wire logic [5:0] idx_i,
  input wire logic kmem_wait_i,
  input wire logic [87:0] kmem_q_i,
  output logic [9:0] kmem_rdaddr_o,
  output logic busy_o,
  output logic done_o,
  output logic v1_o,
  output logic [55:0] data_o
);
  // =====================================================
  // state
  typedef struct packed {
    cphp_kstate_t st;
    logic v1;
    logic [9:0] addr;
    logic [55:0] data;
    logic done;
  } cphp_kr_state_t;

  localparam cphp_kr_state_t KR_RST = '{
    st: CPHP_K_IDLE, v1: 1'b0, addr: CPHP_KADDR_RST,
    data: CPHP_V1KEY_RST, done: 1'b0};

  cphp_kr_state_t kr_r;
  cphp_kr_state_t kr_nxt;

  always_comb begin
    kr_nxt = kr_r;
    kr_nxt.done = 1'b0;
    case (kr_r.st)
      CPHP_K_IDLE: begin
        if (start_i) begin
          kr_nxt.v1 = v1_i;
          if (v1_i) begin
            kr_nxt.addr = {idx_i, 4'h0};
          end else begin
            kr_nxt.addr = {6'h00, 2'b00, idx_i[1:0]};
          end
          kr_nxt.st = CPHP_K_WAIT;
        end
      end
      CPHP_K_WAIT: begin
        if (!kmem_wait_i) begin
          if (kr_r.v1) begin
            kr_nxt.data = kmem_q_i[87:32];
          end else begin
            kr_nxt.data = {24'h00_0000, kmem_q_i[31:0]};
          end
          kr_nxt.done = 1'b1;
          kr_nxt.st = CPHP_K_DONE;
        end
      end
      CPHP_K_DONE: begin
        // one idle turn keeps back to back reads apart
        kr_nxt.st = CPHP_K_IDLE;
      end
      default: begin
        kr_nxt = KR_RST;
      end
    endcase
    if (rst_i) begin
      kr_nxt = KR_RST;
    end
  end

  always_ff @(posedge mclk_i) begin
    kr_r <= kr_nxt;
  end

  assign kmem_rdaddr_o = kr_r.addr;
  assign busy_o = (kr_r.st != CPHP_K_IDLE);
  assign done_o = kr_r.done;
  assign v1_o = kr_r.v1;
  assign data_o = kr_r.data;

  // =====================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence seq_waiting;
    (kr_r.st == CPHP_K_WAIT) && kmem_wait_i;
  endsequence

  chk_addr_hold: assert property (
    seq_waiting |=> $stable(kmem_rdaddr_o))
    else $error("key address moved while store busy");
  chk_key_sample: assert property (
    ((kr_r.st == CPHP_K_WAIT) && !kmem_wait_i && kr_r.v1)
      |=> done_o && (data_o == $past(kmem_q_i[87:32])))
    else $error("wide key not taken one cycle after address");
  chk_rsvd_bits: assert property (
    busy_o && !kr_r.v1 |-> kmem_rdaddr_o[9:2] == 8'h00)
    else $error("reserved key address bits driven");
  chk_wide_field: assert property (
    busy_o && kr_r.v1 |-> kmem_rdaddr_o[3:0] == 4'h0)
    else $error("wide key address not in upper field");
endmodule
`default_nettype wire

//--- src/cphp_host_ports.sv
/*
  host ports of the content protection engine: word addressed
  register slave for message and key traffic, key store read port.
  assumes a processor that waits for read valid and a key store
  that follows the wait protocol; everything on mclk_i.
*/
// Operation
// - port exists only with protection enabled
// - older key kind needs no crypto clock
// - writes no wait, reads one wait
// - slave address is byte address over four
// - messages move as handshaked word bursts
// - key address fields [3:0] and [9:4]
// - key sampled one cycle after address
// - internal key option removes key read port (here the port stays, held idle at address 0)
`timescale 1ns/1ps
`default_nettype none
module cphp_host_ports
  import cphp_pkg::*;
#(
  parameter bit SUPPORT_V2 = 1'b1,
  parameter bit SUPPORT_V1 = 1'b1,
  parameter bit KEY_MGMT = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] csr_addr_i,
  input wire logic csr_wr_i,
  input wire logic csr_rd_i,
  input wire logic [31:0] csr_wrdata_i,
  output logic [31:0] csr_rddata_o,
  output logic csr_rdvalid_o,
  input wire logic kmem_wait_i,
  input wire logic [87:0] kmem_q_i,
  output logic [9:0] kmem_rdaddr_o
);
  // =====================================================
  // build options
  // whole port inert unless a kind is supported
  localparam bit PORT_EN = SUPPORT_V2 | SUPPORT_V1;
  // internal keys leave the read port idle
  localparam bit EXT_KEYS = PORT_EN & ~KEY_MGMT;

  function automatic logic is_msg(input logic [7:0] a);
    is_msg = (a[7:4] == CPHP_OFS_MSG_BASE[7:4]);
  endfunction

  // =====================================================
  // state
  typedef struct packed {
    logic [31:0] rddata;
    logic rdvalid;
    logic v1sel;
    logic [5:0] idx;
    logic start;
    logic done;
    logic [31:0] v2key;
    logic [55:0] v1key;
    logic [15:0][31:0] msg;
  } cphp_top_state_t;

  localparam cphp_top_state_t TOP_RST = '{
    rddata: CPHP_WORD_RST, rdvalid: 1'b0, v1sel: 1'b0,
    idx: CPHP_IDX_RST, start: 1'b0, done: 1'b0,
    v2key: CPHP_WORD_RST, v1key: CPHP_V1KEY_RST,
    msg: '0};

  cphp_top_state_t top_r;
  cphp_top_state_t top_nxt;

  logic kr_busy;
  logic kr_done;
  logic kr_v1;
  logic [55:0] kr_data;
  logic [31:0] status_word;
  logic start_ok;

  assign status_word = {27'h000_0000, KEY_MGMT, SUPPORT_V1, SUPPORT_V2,
                        top_r.done, kr_busy};
  // older kind runs on the main clock alone
  assign start_ok = EXT_KEYS & ~kr_busy & ~top_r.start &
    (csr_wrdata_i[CPHP_CTRL_V1_BIT] ? SUPPORT_V1 : SUPPORT_V2);

  // =====================================================
  // register port and key capture
  always_comb begin
    top_nxt = top_r;
    top_nxt.start = 1'b0;
    top_nxt.rdvalid = 1'b0;
    if (PORT_EN && csr_wr_i) begin
      // writes land at this edge, no wait
      if (is_msg(csr_addr_i)) begin
        // burst words land back to back
        top_nxt.msg[csr_addr_i[3:0]] = csr_wrdata_i;
      end else if (csr_addr_i == CPHP_OFS_CTRL && !kr_busy) begin
        top_nxt.v1sel = csr_wrdata_i[CPHP_CTRL_V1_BIT];
        top_nxt.idx = csr_wrdata_i[CPHP_CTRL_IDX_LSB +: 6];
        top_nxt.start = csr_wrdata_i[CPHP_CTRL_START_BIT] & start_ok;
      end else if (csr_addr_i == CPHP_OFS_STATUS &&
                   csr_wrdata_i[CPHP_STS_DONE_BIT]) begin
        top_nxt.done = 1'b0;
      end
    end
    // a finishing read beats a clear in the same cycle
    if (kr_done) begin
      top_nxt.done = 1'b1;
      if (kr_v1) begin
        top_nxt.v1key = kr_data;
      end else begin
        top_nxt.v2key = kr_data[31:0];
      end
    end
    // read data one cycle after request
    if (PORT_EN && csr_rd_i && !csr_wr_i) begin
      top_nxt.rdvalid = 1'b1;
      if (is_msg(csr_addr_i)) begin
        top_nxt.rddata = top_r.msg[csr_addr_i[3:0]];
      end else begin
        case (csr_addr_i)
          CPHP_OFS_CTRL: begin
            top_nxt.rddata = {18'h0_0000, top_r.idx, 6'h00,
                              top_r.v1sel, 1'b0};
          end
          CPHP_OFS_STATUS: begin
            top_nxt.rddata = status_word;
          end
          CPHP_OFS_V2KEY: begin
            top_nxt.rddata = top_r.v2key;
          end
          CPHP_OFS_V1KEY_LO: begin
            top_nxt.rddata = top_r.v1key[31:0];
          end
          CPHP_OFS_V1KEY_HI: begin
            top_nxt.rddata = {8'h00, top_r.v1key[55:32]};
          end
          default: begin
            top_nxt.rddata = CPHP_WORD_RST;
          end
        endcase
      end
    end
    // reset clears control, status and keys
    if (rst_i) begin
      top_nxt = TOP_RST;
    end
  end

  always_ff @(posedge mclk_i) begin
    top_r <= top_nxt;
  end

  assign csr_rddata_o = top_r.rddata;
  assign csr_rdvalid_o = top_r.rdvalid;

  // =====================================================
  // key store sequencer
  cphp_key_reader u_key_reader (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(top_r.start),
    .v1_i(top_r.v1sel),
    .idx_i(top_r.idx),
    .kmem_wait_i(kmem_wait_i),
    .kmem_q_i(kmem_q_i),
    .kmem_rdaddr_o(kmem_rdaddr_o),
    .busy_o(kr_busy),
    .done_o(kr_done),
    .v1_o(kr_v1),
    .data_o(kr_data)
  );

  // =====================================================
  // checks
  sequence seq_msg_write;
    csr_wr_i && is_msg(csr_addr_i);
  endsequence
  sequence seq_same_read;
    csr_rd_i && !csr_wr_i && (csr_addr_i == $past(csr_addr_i));
  endsequence

  chk_read_latency: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (PORT_EN && csr_rd_i && !csr_wr_i) |=> csr_rdvalid_o ##1 1'b1)
    else $error("read data not valid one cycle after request");
  chk_no_stray_valid: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !(csr_rd_i && !csr_wr_i) |=> !csr_rdvalid_o)
    else $error("read valid without a read");
  chk_burst_word: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (PORT_EN && 1'b1) throughout (seq_msg_write ##1 seq_same_read)
      |=> csr_rddata_o == $past(csr_wrdata_i, 2))
    else $error("message word not written without wait");
  chk_port_inert: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    !PORT_EN |-> !csr_rdvalid_o && (kmem_rdaddr_o == CPHP_KADDR_RST))
    else $error("port active while protection not built");
  chk_int_keys_quiet: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    KEY_MGMT |-> !kr_busy && (kmem_rdaddr_o == CPHP_KADDR_RST))
    else $error("key read port used with internal keys");
  chk_reset_clear: assert property (
    @(posedge mclk_i)
    rst_i |=> !csr_rdvalid_o && (csr_rddata_o == CPHP_WORD_RST) &&
      !kr_busy && !top_r.done)
    else $error("state not cleared by reset");
  chk_done_wins: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    kr_done |=> top_r.done)
    else $error("key done lost against clear");
endmodule
`default_nettype wire

//--- testbench/cphp_key_store_model.sv
/*
  behavioural key store on the far side of the key read port.
  assumes the reader moves its address only to start a new read.
*/
`timescale 1ns/1ps
`default_nettype none
module cphp_key_store_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [3:0] slow_i,
  input wire logic [9:0] rdaddr_i,
  output logic wait_o,
  output logic [87:0] q_o
);
  // ==========================================================
  // wait timing
  logic [9:0] last_r;
  logic [3:0] cnt_r;
  logic [87:0] pat;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      last_r <= 10'h000;
      cnt_r <= 4'h0;
    end else if (rdaddr_i != last_r) begin
      last_r <= rdaddr_i;
      cnt_r <= slow_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  // wait high from new address until key ready
  assign wait_o = (cnt_r != 4'h0) || (rdaddr_i != last_r);
  // ==========================================================
  // key data
  // 32 bit newer key low, 56 bit older key above
  assign pat = {16'h3c3c, 34'h0, rdaddr_i[9:4], 28'h5a5a000, rdaddr_i[3:0]};
  // not ready: inverted so a stale sample never matches
  assign q_o = wait_o ? ~pat : pat;
endmodule
`default_nettype wire

//--- testbench/testbench.sv
/*
  self checking bench for the content protection host ports.
  assumes the key store model and the register map of the design.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import cphp_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] csr_addr_i = 8'h00;
  logic csr_wr_i = 1'b0;
  logic csr_rd_i = 1'b0;
  logic [31:0] csr_wrdata_i = 32'h0;
  logic [31:0] csr_rddata_o;
  logic csr_rdvalid_o;
  logic kmem_wait_i;
  logic [87:0] kmem_q_i;
  logic [9:0] kmem_rdaddr_o;
  logic [3:0] slow = 4'h0;
  logic [31:0] d;
  int failures = 0;
  int cmp_count = 0;
  cphp_host_ports uut (.mclk_i(mclk_i), .rst_i(rst_i),
    .csr_addr_i(csr_addr_i), .csr_wr_i(csr_wr_i), .csr_rd_i(csr_rd_i),
    .csr_wrdata_i(csr_wrdata_i), .csr_rddata_o(csr_rddata_o),
    .csr_rdvalid_o(csr_rdvalid_o), .kmem_wait_i(kmem_wait_i),
    .kmem_q_i(kmem_q_i), .kmem_rdaddr_o(kmem_rdaddr_o));
  cphp_key_store_model store (.mclk_i(mclk_i), .rst_i(rst_i),
    .slow_i(slow), .rdaddr_i(kmem_rdaddr_o), .wait_o(kmem_wait_i),
    .q_o(kmem_q_i));
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  // ==========================================================
  // bus tasks, entered and left at a falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    csr_addr_i = a;
    csr_wrdata_i = v;
    csr_wr_i = 1'b1;
    @(negedge mclk_i);
    csr_wr_i = 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    csr_addr_i = a;
    csr_rd_i = 1'b1;
    @(negedge mclk_i);
    csr_rd_i = 1'b0;
    `CHK(csr_rdvalid_o, 1'b1)
    v = csr_rddata_o;
    @(negedge mclk_i);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    `CHK(kmem_rdaddr_o, 10'h000)
    rd(CPHP_OFS_STATUS, d);
    `CHK(d, 32'h0000_000c)
    rd(8'h08, d);
    `CHK(d, 32'h0)
    $display("test reset done");
  endtask
  task automatic t_burst;
    // byte addresses turned into word addresses, every cycle
    for (int i = 0; i < 16; i++) begin
      csr_addr_i = 8'((32'h40 + 4 * i) >> 2);
      csr_wrdata_i = 32'ha5a5_0000 + i;
      csr_wr_i = 1'b1;
      @(negedge mclk_i);
    end
    csr_wr_i = 1'b0;
    csr_rd_i = 1'b1;
    for (int i = 0; i < 16; i++) begin
      csr_addr_i = CPHP_OFS_MSG_BASE + 8'(i);
      @(negedge mclk_i);
      `CHK(csr_rdvalid_o, 1'b1)
      `CHK(csr_rddata_o, 32'ha5a5_0000 + i)
    end
    csr_rd_i = 1'b0;
    csr_addr_i = CPHP_OFS_MSG_BASE;
    csr_wr_i = 1'b1;
    csr_wrdata_i = 32'h0bad_f00d;
    @(negedge mclk_i);
    // write wins, so no read answer
    csr_rd_i = 1'b1;
    @(negedge mclk_i);
    `CHK(csr_rdvalid_o, 1'b0)
    // read right behind the write, no gap
    csr_wr_i = 1'b0;
    @(negedge mclk_i);
    csr_rd_i = 1'b0;
    `CHK(csr_rdvalid_o, 1'b1)
    `CHK(csr_rddata_o, 32'h0bad_f00d)
    $display("test burst done");
  endtask
  task automatic t_key(input logic v1, input logic [5:0] idx,
                       input logic [3:0] s);
    logic [9:0] ea;
    int n;
    ea = v1 ? {idx, 4'h0} : {8'h00, idx[1:0]};
    slow = s;
    wr(CPHP_OFS_CTRL, {18'h0, idx, 6'h0, v1, 1'b1});
    for (n = 0; n < 20 && kmem_rdaddr_o !== ea; n++) @(negedge mclk_i);
    `CHK(kmem_rdaddr_o, ea)
    if (n == 20) begin
      failures++;
      conclude();
    end
    if (s > 4'h4) begin
      rd(CPHP_OFS_STATUS, d);
      `CHK(d[CPHP_STS_BUSY_BIT], 1'b1)
      wr(CPHP_OFS_CTRL, 32'h0000_0101);
      `CHK(kmem_rdaddr_o, ea)
    end
    for (n = 0; n < 40; n++) begin
      rd(CPHP_OFS_STATUS, d);
      if (d[CPHP_STS_DONE_BIT]) break;
    end
    if (n == 40) begin
      failures++;
      conclude();
    end
    if (v1) begin
      rd(CPHP_OFS_V1KEY_LO, d);
      `CHK(d, {26'h0, idx})
      rd(CPHP_OFS_V1KEY_HI, d);
      `CHK(d, 32'h003c_3c00)
    end else begin
      rd(CPHP_OFS_V2KEY, d);
      `CHK(d, {28'h5a5a000, 2'b00, idx[1:0]})
    end
    wr(CPHP_OFS_STATUS, 32'h1 << CPHP_STS_DONE_BIT);
    rd(CPHP_OFS_STATUS, d);
    `CHK(d[CPHP_STS_DONE_BIT], 1'b0)
    $display("test key read done");
  endtask
  task automatic t_midreset;
    slow = 4'h8;
    wr(CPHP_OFS_CTRL, 32'h0000_1503);
    repeat (3) @(negedge mclk_i);
    `CHK(kmem_rdaddr_o, 10'h150)
    rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    rst_i = 1'b0;
    `CHK(kmem_rdaddr_o, 10'h000)
    `CHK(csr_rdvalid_o, 1'b0)
    @(negedge mclk_i);
    rd(CPHP_OFS_STATUS, d);
    `CHK(d, 32'h0000_000c)
    $display("test mid reset done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    @(negedge mclk_i);
    t_reset();
    t_burst();
    t_key(1'b0, 6'h03, 4'h0);
    t_key(1'b1, 6'h2b, 4'h7);
    t_key(1'b1, 6'h3f, 4'h0);
    t_key(1'b0, 6'h01, 4'h6);
    t_midreset();
    conclude();
  end
endmodule
`default_nettype wire
